// >>> logic/e1_error_count_and_slot_monitor.sv
// Error counters, interval latching, slot snoop and byte-wide register port
`default_nettype none
`include "e1_err_params.svh"

// Functional notes
// - Far-end count 10 bits over 0x04/0x05
// - 0x04 bits 7..2 hold frame-error low six
// - 12-bit count of errored alignment words
// - No frame-error counting while sync lost
// - No frame-error counting while hunting alignment
// - Frame-error counter holds 4000 without saturating
// - Frame-error top six in 0x02 bits 7..2
// - 0x02 bits 1..0 hold checksum count top
// - Monitor one transmit and one receive slot
// - 0xa8 select picks transmit slot into 0xa9
// - 0xaa select picks receive slot into 0xab
// - Transmit snoop bit 7 is first sent
// - Receive snoop bit 7 is first received
// - Latch counts each interval; saturate, never wrap
// - Far-end counts zero E-bits, pauses on sync loss
module e1_error_count_and_slot_monitor #(
	parameter int unsigned SLOW_CYCLES = `SLOW_INTERVAL_CYCLES,
	parameter int unsigned FAST_CYCLES = `FAST_INTERVAL_CYCLES
) (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic [7:0]          busAddr,
	input  wire logic [7:0]          busWrData,
	input  wire logic                busWr,
	input  wire logic                busRd,
	output logic [7:0]               busRdData,
	input  wire logic                fastInterval,
	input  wire logic                receive_sync_lost,
	input  wire logic                alignHunt,
	input  wire logic                casHunt,
	input  wire logic                crcHunt,
	input  wire logic                frameAlignErr,
	input  wire logic                crcErr,
	input  wire logic                eBitValid,
	input  wire logic                eBit,
	input  wire logic                txBitValid,
	input  wire logic                txBit,
	input  wire e1_err_pkg::slot_t   txBitSlot,
	input  wire logic [2:0]          txBitIdx,
	input  wire logic                rxBitValid,
	input  wire logic                rxBit,
	input  wire e1_err_pkg::slot_t   rxBitSlot,
	input  wire logic [2:0]          rxBitIdx,
	output logic                     intervalTick
);
	////////////////////////////////////////////////////////////////////////////////
	// Saturating increment shared by all counters

	function automatic e1_err_pkg::count12_t satInc(
		input e1_err_pkg::count12_t cnt,
		input e1_err_pkg::count12_t maxVal,
		input logic                 inc
	);
		if (inc && (cnt != maxVal)) begin
			satInc = e1_err_pkg::count12_t'(cnt + 12'h001);
		end else begin
			satInc = cnt;
		end
	endfunction : satInc

	// Pairs six count bits with the top two bits of a ten-bit count in one byte
	function automatic e1_err_pkg::byte_t packShared(
		input logic [5:0] sixBits,
		input logic [1:0] topTwo
	);
		packShared = {sixBits, topTwo};
	endfunction : packShared

	// Write strobe decode for one register address
	function automatic logic wrHit(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] target
	);
		wrHit = wr && (addr == target);
	endfunction : wrHit

	////////////////////////////////////////////////////////////////////////////////
	// Interval timer

	e1_err_pkg::interval_e intervalMode;
	logic [31:0]           timer_r;
	logic [31:0]           timer_nxt;
	logic                  tick_r;
	logic                  tick_nxt;

	// Thirty-two bits keep the one-second cycle count at the system clock in range
	assign intervalMode = fastInterval ? e1_err_pkg::INTERVAL_FAST : e1_err_pkg::INTERVAL_SLOW;

	always_comb begin
		logic [31:0] limit;
		limit = 32'h0;
		case (intervalMode)
			e1_err_pkg::INTERVAL_FAST: limit = FAST_CYCLES - 1;
			e1_err_pkg::INTERVAL_SLOW: limit = SLOW_CYCLES - 1;
			default:                   limit = SLOW_CYCLES - 1;
		endcase
		tick_nxt  = 1'b0;
		timer_nxt = 32'(timer_r + 32'h1);
		// Switching to the short interval mid-count ends the current interval at once if the count is at or past the short limit, else at that limit
		if (timer_r >= limit) begin
			timer_nxt = 32'h0;
			tick_nxt  = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			timer_r <= 32'h0;
			tick_r  <= 1'b0;
		end else begin
			timer_r <= timer_nxt;
			tick_r  <= tick_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Running counters and latched counts

	e1_err_pkg::count12_t fasRun_r;
	e1_err_pkg::count12_t fasRun_nxt;
	e1_err_pkg::count12_t crcRun_r;
	e1_err_pkg::count12_t crcRun_nxt;
	e1_err_pkg::count12_t febeRun_r;
	e1_err_pkg::count12_t febeRun_nxt;
	e1_err_pkg::count12_t fasHold_r;
	e1_err_pkg::count12_t fasHold_nxt;
	e1_err_pkg::count12_t crcHold_r;
	e1_err_pkg::count12_t crcHold_nxt;
	e1_err_pkg::count12_t febeHold_r;
	e1_err_pkg::count12_t febeHold_nxt;
	logic                 fasCount;
	logic                 crcCount;
	logic                 febeCount;
	logic                 crcLevelLoss;

	always_comb begin
		crcLevelLoss = receive_sync_lost || crcHunt;
		fasCount     = frameAlignErr && !receive_sync_lost
			&& !alignHunt && !casHunt && !crcHunt;
		crcCount     = crcErr && !crcLevelLoss;
		febeCount    = eBitValid && !eBit && !crcLevelLoss;
		if (tick_r) begin
			// An event on the latching edge already counts into the next interval
			fasRun_nxt   = satInc(12'h000, `FAS_MAX, fasCount);
			crcRun_nxt   = satInc(12'h000, `TEN_MAX, crcCount);
			febeRun_nxt  = satInc(12'h000, `TEN_MAX, febeCount);
		end else begin
			// 12 bits reach 4095, above the 4000 worst case, yet still clamp
			fasRun_nxt   = satInc(fasRun_r, `FAS_MAX, fasCount);
			crcRun_nxt   = satInc(crcRun_r, `TEN_MAX, crcCount);
			febeRun_nxt  = satInc(febeRun_r, `TEN_MAX, febeCount);
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fasRun_r   <= 12'h000;
			crcRun_r   <= 12'h000;
			febeRun_r  <= 12'h000;
		end else begin
			fasRun_r   <= fasRun_nxt;
			crcRun_r   <= crcRun_nxt;
			febeRun_r  <= febeRun_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Latched counts, the host has a whole interval to read them

	always_comb begin
		fasHold_nxt  = fasHold_r;
		crcHold_nxt  = crcHold_r;
		febeHold_nxt = febeHold_r;
		if (tick_r) begin
			fasHold_nxt  = fasRun_r;
			crcHold_nxt  = crcRun_r;
			febeHold_nxt = febeRun_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fasHold_r  <= 12'h000;
			crcHold_r  <= 12'h000;
			febeHold_r <= 12'h000;
		end else begin
			fasHold_r  <= fasHold_nxt;
			crcHold_r  <= crcHold_nxt;
			febeHold_r <= febeHold_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	logic [7:0] ctrlFour_r;
	logic [7:0] ctrlFour_nxt;
	logic [7:0] ctrlFive_r;
	logic [7:0] ctrlFive_nxt;

	// All eight bits are kept for readback; only bits 4..0 act inside this block
	always_comb begin
		ctrlFour_nxt = ctrlFour_r;
		ctrlFive_nxt = ctrlFive_r;
		if (wrHit(busWr, busAddr, `ADDR_CTRL_FOUR)) begin
			ctrlFour_nxt = busWrData;
		end
		if (wrHit(busWr, busAddr, `ADDR_CTRL_FIVE)) begin
			ctrlFive_nxt = busWrData;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrlFour_r <= `CTRL_RESET;
			ctrlFive_r <= `CTRL_RESET;
		end else begin
			ctrlFour_r <= ctrlFour_nxt;
			ctrlFive_r <= ctrlFive_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slot snoop, one per direction, independent selects

	e1_err_pkg::slot_t txSelect;
	e1_err_pkg::slot_t rxSelect;
	logic [7:0]        txSnoop;
	logic [7:0]        rxSnoop;

	// Code is channel minus one, which equals the timeslot number
	assign txSelect = ctrlFour_r[`SEL_MSB:`SEL_LSB];
	assign rxSelect = ctrlFive_r[`SEL_MSB:`SEL_LSB];

	// The two directions come from separate streams and never share a select
	e1_slot_capture txCapture (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.bitValid   (txBitValid),
		.bitData    (txBit),
		.bitSlot    (txBitSlot),
		.bitIdx     (txBitIdx),
		.slotSelect (txSelect),
		.snoop      (txSnoop)
	);

	e1_slot_capture rxCapture (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.bitValid   (rxBitValid),
		.bitData    (rxBit),
		.bitSlot    (rxBitSlot),
		.bitIdx     (rxBitIdx),
		.slotSelect (rxSelect),
		.snoop      (rxSnoop)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;

	// Read data is a register: it answers one edge after the strobe and then holds
	// until the next read, even while the counts behind it move on
	always_comb begin
		rdData_nxt = rdData_r;
		if (busRd) begin
			case (busAddr)
				`ADDR_CRC_HIGH_FAS_TOP: rdData_nxt = packShared(fasHold_r[11:6], crcHold_r[9:8]);
				`ADDR_CRC_LOW:          rdData_nxt = crcHold_r[7:0];
				`ADDR_FAS_LOW_FEBE_TOP: rdData_nxt = packShared(fasHold_r[5:0], febeHold_r[9:8]);
				`ADDR_FEBE_LOW:         rdData_nxt = febeHold_r[7:0];
				`ADDR_CTRL_FOUR:        rdData_nxt = ctrlFour_r;
				`ADDR_TX_SNOOP:         rdData_nxt = txSnoop;
				`ADDR_CTRL_FIVE:        rdData_nxt = ctrlFive_r;
				`ADDR_RX_SNOOP:         rdData_nxt = rxSnoop;
				// Unmapped addresses read as zero
				default:                rdData_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdData_r <= 8'h00;
		end else begin
			rdData_r <= rdData_nxt;
		end
	end

	assign busRdData    = rdData_r;
	assign intervalTick = tick_r;
endmodule : e1_error_count_and_slot_monitor
`default_nettype wire

// >>> logic/e1_err_params.svh
// Offsets, field positions, reset values and timing figures of the error count and slot snoop block
`ifndef E1_ERR_PARAMS_SVH
`define E1_ERR_PARAMS_SVH

`define ADDR_CRC_HIGH_FAS_TOP  8'h02
`define ADDR_CRC_LOW           8'h03
`define ADDR_FAS_LOW_FEBE_TOP  8'h04
`define ADDR_FEBE_LOW          8'h05
`define ADDR_CTRL_FOUR         8'ha8
`define ADDR_TX_SNOOP          8'ha9
`define ADDR_CTRL_FIVE         8'haa
`define ADDR_RX_SNOOP          8'hab

`define SEL_MSB                4
`define SEL_LSB                0
`define FAS_WIDTH              12
`define TEN_WIDTH              10
`define FAS_MAX                12'hfff
`define TEN_MAX                12'h3ff
`define CTRL_RESET             8'h00
`define SNOOP_RESET            8'h00
`define LAST_BIT_IDX           3'h7

`define CLK_MHZ                100
`define SLOW_INTERVAL_US       1000000
`define FAST_INTERVAL_US       62500
`define SLOW_INTERVAL_CYCLES   (`SLOW_INTERVAL_US * `CLK_MHZ)
`define FAST_INTERVAL_CYCLES   (`FAST_INTERVAL_US * `CLK_MHZ)

`endif

// >>> logic/e1_err_pkg.sv
// Types shared by the error count and slot snoop block
`default_nettype none
package e1_err_pkg;
	typedef logic [11:0] count12_t;
	typedef logic [4:0]  slot_t;
	typedef logic [7:0]  byte_t;
	typedef enum logic {INTERVAL_SLOW, INTERVAL_FAST} interval_e;
endpackage : e1_err_pkg
`default_nettype wire

// >>> logic/e1_slot_capture.sv
// Captures one selected timeslot of a serial stream as a whole byte per frame
`default_nettype none
`include "e1_err_params.svh"
module e1_slot_capture (
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	input  wire logic                bitValid,
	input  wire logic                bitData,
	input  wire e1_err_pkg::slot_t   bitSlot,
	input  wire logic [2:0]          bitIdx,
	input  wire e1_err_pkg::slot_t   slotSelect,
	output logic [7:0]               snoop
);
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] snoop_r;
	logic [7:0] snoop_nxt;
	logic       hit;

	always_comb begin
		hit       = bitValid && (bitSlot == slotSelect);
		shift_nxt = shift_r;
		snoop_nxt = snoop_r;
		if (hit) begin
			// First bit on the wire ends up in bit 7
			shift_nxt = {shift_r[6:0], bitData};
			// Only a complete byte is published, so a read never sees a half-filled slot
			if (bitIdx == `LAST_BIT_IDX) begin
				snoop_nxt = {shift_r[6:0], bitData};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shift_r <= `SNOOP_RESET;
			snoop_r <= `SNOOP_RESET;
		end else begin
			shift_r <= shift_nxt;
			snoop_r <= snoop_nxt;
		end
	end

	assign snoop = snoop_r;
endmodule : e1_slot_capture
`default_nettype wire

// >>> testbench/e1_err_monitor.sv
// Port timing checks for the error count and slot snoop block
`default_nettype none
module e1_err_monitor (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic       busWr,
	input wire logic       busRd,
	input wire logic [7:0] busRdData,
	input wire logic       txBitValid,
	input wire logic       rxBitValid,
	input wire logic       intervalTick
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic gap   = !(busRd || intervalTick);
	wire logic rdHi  = busRd && busAddr == 8'h02 && !intervalTick;
	wire logic rdMid = busRd && busAddr == 8'h04 && !intervalTick;
	wire logic rdLo  = busRd && busAddr == 8'h05 && !intervalTick;
	wire logic rdTx  = busRd && busAddr == 8'ha9 && !txBitValid;
	wire logic rdRx  = busRd && busAddr == 8'hab && !rxBitValid;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	tick_gap_a: assert property (
		intervalTick |=> !intervalTick [*8]) else $error("ticks too close");
	tx_sel_a: assert property (
		(busWr && busAddr == 8'ha8) ##1 !busWr ##1 (busRd && !busWr && busAddr == 8'ha8)
		|=> busRdData == $past(busWrData, 3)) else $error("tx select readback");
	rx_sel_a: assert property (
		(busWr && busAddr == 8'haa) ##1 !busWr ##1 (busRd && !busWr && busAddr == 8'haa)
		|=> busRdData == $past(busWrData, 3)) else $error("rx select readback");
	crc_top_hold_a: assert property (
		rdHi ##1 gap ##1 rdHi |=> busRdData == $past(busRdData)) else $error("byte 02 moved");
	fas_low_hold_a: assert property (
		rdMid ##1 gap ##1 rdMid |=> busRdData == $past(busRdData)) else $error("byte 04 moved");
	febe_low_hold_a: assert property (
		rdLo ##1 gap ##1 rdLo |=> busRdData == $past(busRdData)) else $error("byte 05 moved");
	tx_snoop_hold_a: assert property (
		(rdTx && !$past(txBitValid)) ##1 (gap && !txBitValid) ##1 rdTx |=> busRdData == $past(busRdData))
		else $error("tx snoop moved");
	rx_snoop_hold_a: assert property (
		(rdRx && !$past(rxBitValid)) ##1 (gap && !rxBitValid) ##1 rdRx |=> busRdData == $past(busRdData))
		else $error("rx snoop moved");
endmodule : e1_err_monitor
bind e1_error_count_and_slot_monitor e1_err_monitor u_mon (.sys_clk, .rstn, .busAddr, .busWrData, .busWr,
	.busRd, .busRdData, .txBitValid, .rxBitValid, .intervalTick);
`default_nettype wire

// >>> testbench/e1_line_model.sv
// Line side stand-in: transmit and receive serial streams, one bit per cycle
`default_nettype none
module e1_line_model (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic [7:0] txSeed,
	input  wire logic [7:0] rxSeed,
	output logic            txBitValid,
	output logic            txBit,
	output logic [4:0]      txBitSlot,
	output logic [2:0]      txBitIdx,
	output logic            rxBitValid,
	output logic            rxBit,
	output logic [4:0]      rxBitSlot,
	output logic [2:0]      rxBitIdx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pos_r;
	logic [7:0] txByte;
	logic [7:0] rxByte;
	////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pos_r <= 8'h00;
		end else begin
			pos_r <= 8'(pos_r + 8'h01);
		end
	end
	// Slot number folded into each byte so a wrong select reads back wrong
	assign txByte = {pos_r[7:3], 3'h5} ^ txSeed;
	assign rxByte = {pos_r[7:3], 3'h2} ^ rxSeed;
	assign {txBitSlot, txBitIdx} = pos_r;
	assign {rxBitSlot, rxBitIdx} = pos_r;
	assign txBitValid = run;
	assign rxBitValid = run;
	// Idle data toggles so a stale bit is never taken for live data
	assign txBit = run ? txByte[3'h7 - pos_r[2:0]] : pos_r[0];
	assign rxBit = run ? rxByte[3'h7 - pos_r[2:0]] : ~pos_r[0];
endmodule : e1_line_model
`default_nettype wire

// >>> testbench/e1_error_count_and_slot_monitor_tb_top.sv
// Self-checking bench for the error count and slot snoop block
`default_nettype none
module e1_error_count_and_slot_monitor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FAST_C = 50;
	localparam logic [7:0] MAP [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'h10};
	logic sys_clk = 1'b0, rstn = 1'b0, busWr = 1'b0, busRd = 1'b0, fastInterval = 1'b0, run = 1'b0;
	logic receive_sync_lost = 1'b0, alignHunt = 1'b0, casHunt = 1'b0, crcHunt = 1'b0;
	logic frameAlignErr = 1'b0, crcErr = 1'b0, eBitValid = 1'b0, eBit = 1'b1;
	logic [7:0] busAddr = 8'h00, busWrData = 8'h00, txSeed = 8'h00, rxSeed = 8'h00, busRdData;
	logic txBitValid, txBit, rxBitValid, rxBit, intervalTick;
	logic [4:0] txBitSlot, rxBitSlot;
	logic [2:0] txBitIdx, rxBitIdx;
	int failCount = 0, nTests = 0;
	always #5 sys_clk = ~sys_clk;
	e1_error_count_and_slot_monitor #(.SLOW_CYCLES(5000), .FAST_CYCLES(FAST_C)) u_dut (.sys_clk, .rstn,
		.busAddr, .busWrData, .busWr, .busRd, .busRdData, .fastInterval, .receive_sync_lost, .alignHunt,
		.casHunt, .crcHunt, .frameAlignErr, .crcErr, .eBitValid, .eBit, .txBitValid, .txBit, .txBitSlot,
		.txBitIdx, .rxBitValid, .rxBit, .rxBitSlot, .rxBitIdx, .intervalTick);
	e1_line_model u_line (.sys_clk, .rstn, .run, .txSeed, .rxSeed, .txBitValid, .txBit, .txBitSlot,
		.txBitIdx, .rxBitValid, .rxBit, .rxBitSlot, .rxBitIdx);
	////////////////////////////////////////
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge sys_clk);
		busWr <= 1'b0;
	endtask : wr
	// Each address is read twice so the hold checks see a repeat
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		repeat (2) begin
			@(posedge sys_clk);
			busAddr <= a;
			busRd <= 1'b1;
			@(posedge sys_clk);
			busRd <= 1'b0;
			@(negedge sys_clk);
			cmp($sformatf("reg %h", a), {8'h00, e}, {8'h00, busRdData});
		end
	endtask : rd
	task automatic waitTick(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (intervalTick !== 1'b1 && n < 6000);
		// A tick that never comes is a failure, not a silent pass
		cmp("interval tick", 16'h0001, {15'h0000, intervalTick});
	endtask : waitTick
	task automatic counts(input logic [11:0] f, input logic [9:0] c, input logic [9:0] e);
		rd(8'h02, {f[11:6], c[9:8]});
		rd(8'h03, c[7:0]);
		rd(8'h04, {f[5:0], e[9:8]});
		rd(8'h05, e[7:0]);
	endtask : counts
	function automatic logic [7:0] slotByte(input logic [4:0] s, input logic [2:0] k, input logic [7:0] sd);
		return {s, k} ^ sd;
	endfunction : slotByte
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#400000;
		failCount++;
		end_of_test();
	end
	initial begin
		int k, n, f, c, e;
		logic [4:0] ts, rs;
		logic [7:0] w;
		logic [3:0] g;
		logic [2:0] ev;
		void'($urandom(32'h585cf841));
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (MAP[i]) rd(MAP[i], 8'h00);
		$display("reset values done");
		for (k = 0; k < 4; k++) begin
			ts = k == 0 ? 5'h05 : k == 1 ? 5'h1f : 5'($urandom);
			rs = k == 0 ? 5'h0e : k == 1 ? 5'h00 : 5'($urandom);
			@(posedge sys_clk);
			txSeed <= 8'($urandom);
			rxSeed <= 8'($urandom);
			w = {3'($urandom), ts};
			wr(8'ha8, w);
			rd(8'ha8, w);
			w = {3'($urandom), rs};
			wr(8'haa, w);
			rd(8'haa, w);
			@(posedge sys_clk);
			run <= 1'b1;
			repeat (300) @(posedge sys_clk);
			run <= 1'b0;
			wr(8'ha9, 8'hff);
			rd(8'ha9, slotByte(ts, 3'h5, txSeed));
			rd(8'hab, slotByte(rs, 3'h2, rxSeed));
		end
		$display("snoop test done");
		waitTick(n);
		for (k = 0; k < 16'hfa0; k++) begin
			frameAlignErr <= 1'b1;
			crcErr <= k < 16'h406;
			eBitValid <= k < 16'h4b0;
			eBit <= k >= 16'h44c;
			@(posedge sys_clk);
		end
		{frameAlignErr, crcErr, eBitValid} <= 3'h0;
		waitTick(n);
		counts(12'hfa0, 10'h3ff, 10'h3ff);
		@(posedge sys_clk);
		fastInterval <= 1'b1;
		waitTick(n);
		waitTick(n);
		cmp("fast interval", 16'(FAST_C), 16'(n));
		f = 0;
		c = 0;
		e = 0;
		for (k = 0; k < 40; k++) begin
			g = k[1] ? 4'($urandom) : 4'h0;
			ev = 3'($urandom);
			{receive_sync_lost, alignHunt, casHunt, crcHunt} <= g;
			{frameAlignErr, crcErr, eBitValid} <= ev;
			eBit <= k[2];
			f += int'(ev[2] && g == 4'h0);
			c += int'(ev[1] && !g[3] && !g[0]);
			e += int'(ev[0] && !k[2] && !g[3] && !g[0]);
			@(posedge sys_clk);
		end
		{receive_sync_lost, alignHunt, casHunt, crcHunt} <= 4'h0;
		{frameAlignErr, crcErr, eBitValid} <= 3'h0;
		waitTick(n);
		counts(12'(f), 10'(c), 10'(e));
		$display("counter tests done");
		end_of_test();
	end
endmodule : e1_error_count_and_slot_monitor_tb_top
`default_nettype wire
